/* File: sim/mem_ctrl_model.sv */
// controller stand-in: drives selects, shared address and write words
// assumes tb calls its tasks; pins change just after mclk rises
`timescale 1ns/100ps
module mem_ctrl_model (
  // clock
  input  wire logic   mclk,
  // selects and shared address
  output logic        read_port_select_n,
  output logic        write_port_select_n,
  output logic [7:0]  addr,
  // write words and lane selects per phase
  output logic [17:0] wdata_rise,
  output logic [17:0] wdata_fall,
  output logic [1:0]  byte_write_select_n_rise,
  output logic [1:0]  byte_write_select_n_fall
);
  // idle: both ports deselected
  initial begin
    read_port_select_n  = 1'b1;
    write_port_select_n = 1'b1;
    {addr, wdata_rise, wdata_fall} = '0;
    {byte_write_select_n_rise, byte_write_select_n_fall} = '1;
  end

  // one write burst: start cycle, then two cycles of word pairs
  task automatic wr(input logic [7:0] a, input logic [71:0] w,
                    input logic [7:0] be_n);
    @(posedge mclk);
    write_port_select_n <= 1'b0;
    addr                <= a;
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk);
      write_port_select_n      <= 1'b1;
      wdata_rise               <= w[36*c +: 18];
      wdata_fall               <= w[36*c+18 +: 18];
      byte_write_select_n_rise <= be_n[4*c +: 2];
      byte_write_select_n_fall <= be_n[4*c+2 +: 2];
    end
    @(posedge mclk);
    wdata_rise <= ~wdata_rise;  // released words must not linger
    wdata_fall <= ~wdata_fall;
  endtask : wr

  // read start held for cyc rises; two means a refused repeat
  task automatic rd(input logic [7:0] a, input int cyc);
    @(posedge mclk);
    read_port_select_n <= 1'b0;
    addr               <= a;
    repeat (cyc) @(posedge mclk);
    read_port_select_n <= 1'b1;
    addr               <= ~a;
  endtask : rd
endmodule : mem_ctrl_model

/* File: sim/tb_top.sv */
// self-checking bench for the split-port burst memory core
// assumes default 18-bit width; mem_ctrl_model plays the controller
`timescale 1ns/100ps
module tb_top;
  logic        mclk, rst_n, pll_disable_n, in_clk_present, out_clk_level;
  logic        read_port_select_n, write_port_select_n;
  logic [7:0]  addr;
  logic [17:0] wdata_rise, wdata_fall, rdata_rise, rdata_fall;
  logic [1:0]  bws_n_rise, bws_n_fall;
  logic        rdata_oe_rise, rdata_oe_fall, pll_locked, imp_pulse;
  logic        single_mode, echo, echo_n;  // echo source select, echo pair
  logic [17:0] got[$];     // read words in arrival order
  logic        first_fall; // first word came on the falling phase
  int          fail_count, num_checks, n;
  localparam logic [71:0] W0 = 72'h123456789abcdef012;
  localparam logic [71:0] W1 = 72'hfedcba987654321a5c;

  // 50 MHz clock and a toggling output clock level
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) out_clk_level <= ~out_clk_level;

  mem_ctrl_model u_mem_ctrl_model (.mclk(mclk),
    .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr),
    .wdata_rise(wdata_rise), .wdata_fall(wdata_fall),
    .byte_write_select_n_rise(bws_n_rise),
    .byte_write_select_n_fall(bws_n_fall));

  ddr_burst_sram u_ddr_burst_sram (.mclk(mclk), .rst_n(rst_n),
    .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr),
    .wdata_rise(wdata_rise), .wdata_fall(wdata_fall),
    .byte_write_select_n_rise(bws_n_rise),
    .byte_write_select_n_fall(bws_n_fall),
    .pll_disable_n(pll_disable_n), .single_clock_mode(single_mode),
    .in_clk_present(in_clk_present), .out_clk_level(out_clk_level),
    .rdata_rise(rdata_rise), .rdata_fall(rdata_fall),
    .rdata_oe_rise(rdata_oe_rise), .rdata_oe_fall(rdata_oe_fall),
    .echo_clock(echo), .echo_clock_n(echo_n), .pll_locked(pll_locked),
    .impedance_update(imp_pulse));

  // collect read words, rising phase before falling phase
  always @(posedge mclk) begin
    if (rdata_oe_rise) begin
      if (got.size() == 0) first_fall = 1'b0;
      got.push_back(rdata_rise);
    end
    if (rdata_oe_fall) begin
      if (got.size() == 0) first_fall = 1'b1;
      got.push_back(rdata_fall);
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [71:0] exp,
                     input logic [71:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bounded wait for a level, n counts the edges waited
  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 1200) begin
      chk("wait bound", 72'h1, 72'h0);
      print_verdict();
    end
  endtask : wait_hi

  // read one burst and judge words and phase of the first word
  task automatic rd_chk(input logic [7:0] a, input int cyc,
                        input logic [71:0] exp, input logic ff);
    logic [71:0] w;
    got.delete();
    u_mem_ctrl_model.rd(a, cyc);
    repeat (8) @(posedge mclk);
    w = 'x;
    if (got.size() == 4) w = {got[3], got[2], got[1], got[0]};
    chk("burst words", exp, w);
    chk("first phase", {71'h0, ff}, {71'h0, first_fall});
  endtask : rd_chk

  task automatic t_bypass();
    logic [71:0] e;
    logic [7:0]  be;
    be = 8'h99;  // lane selects of the second burst, one bit per lane
    u_mem_ctrl_model.wr(8'h10, W0, 8'h00);
    repeat (4) @(posedge mclk);
    rd_chk(8'h10, 2, W0, 1'b0);
    u_mem_ctrl_model.wr(8'h10, W1, 8'h99);
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 8; i++) e[9*i +: 9] = be[i] ? W0[9*i +: 9]
                                                    : W1[9*i +: 9];
    rd_chk(8'h10, 1, e, 1'b0);
    $display("test bypass and lanes done");
  endtask : t_bypass

  task automatic t_fwd();
    fork
      u_mem_ctrl_model.wr(8'h20, W1, 8'h00);
      begin
        @(posedge mclk);
        rd_chk(8'h20, 1, W1, 1'b0);
      end
    join
    $display("test forwarding done");
  endtask : t_fwd

  // echo pair: toggles from the core clock in single mode, stays inverse
  task automatic t_echo();
    logic e0;
    @(posedge mclk);
    single_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    e0 = echo;
    @(posedge mclk);
    chk("echo toggles", {71'h0, ~e0}, {71'h0, echo});
    chk("echo pair", {71'h0, ~echo}, {71'h0, echo_n});
    single_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("test echo clocks done");
  endtask : t_echo

  task automatic t_pll();
    @(posedge mclk);
    pll_disable_n  <= 1'b1;
    in_clk_present <= 1'b0;
    repeat (3) @(posedge mclk);
    in_clk_present <= 1'b1;
    wait_hi(pll_locked);
    chk("lock time", 72'h1, {71'h0, n >= 1000 && n <= 1010});
    rd_chk(8'h20, 1, W1, 1'b1);
    wait_hi(imp_pulse);
    @(posedge mclk);
    wait_hi(imp_pulse);
    chk("impedance period", 72'd1024, 72'(n + 1));
    $display("test pll and impedance done");
  endtask : t_pll

  initial begin
    rst_n          = 1'b0;
    pll_disable_n  = 1'b0;
    single_mode    = 1'b0;
    in_clk_present = 1'b1;
    out_clk_level  = 1'b0;
    first_fall     = 1'b0;
    fail_count     = 0;
    num_checks     = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("oe after reset", 72'h0, {70'h0, rdata_oe_rise, rdata_oe_fall});
    t_bypass();
    t_fwd();
    t_echo();
    t_pll();
    print_verdict();
  end
endmodule : tb_top

/* File: src/ddr_burst_sram.sv */
// split-port double-rate memory core with burst-of-four accesses
// assumes one mclk cycle per input clock cycle; each data port carries
// the rising-phase and falling-phase word of that cycle side by side
`timescale 1ns/100ps
module ddr_burst_sram #(
  parameter int DW    = sram_pkg::DATA_W,
  parameter int AW    = sram_pkg::ADDR_W,
  parameter int DEPTH = sram_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // controller address and selects
  input  wire logic                 read_port_select_n,
  input  wire logic                 write_port_select_n,
  input  wire logic [AW-1:0]        addr,
  // write data and byte selects, rising then falling phase
  input  wire logic [DW-1:0]        wdata_rise,
  input  wire logic [DW-1:0]        wdata_fall,
  input  wire logic [DW/9-1:0]      byte_write_select_n_rise,
  input  wire logic [DW/9-1:0]      byte_write_select_n_fall,
  // mode and clock status pins
  input  wire logic                 pll_disable_n,
  input  wire logic                 single_clock_mode,
  input  wire logic                 in_clk_present,
  input  wire logic                 out_clk_level,
  // read data, rising then falling phase of the output clock
  output logic      [DW-1:0]        rdata_rise,
  output logic      [DW-1:0]        rdata_fall,
  output logic                      rdata_oe_rise,
  output logic                      rdata_oe_fall,
  // echo clocks and status
  output logic                      echo_clock,
  output logic                      echo_clock_n,
  output logic                      pll_locked,
  output logic                      impedance_update
);

  localparam int LN = DW / sram_pkg::LANE_W;       // lanes per word
  localparam int LW = sram_pkg::BURST_LEN * DW;    // one burst line
  localparam int MW = sram_pkg::BURST_LEN * LN;    // lane enables per line
  localparam int FW = AW + LW + MW;                // queued burst
  localparam int PW = 2 + AW + 2 * DW + 2 * LN + 4; // synchronised pins
  localparam int QW = $clog2(DEPTH + 1);
  localparam int KW = $clog2(sram_pkg::PLL_LOCK_CYC + 1);
  localparam int SW = $clog2(sram_pkg::PLL_RESET_CYC + 1);
  localparam int ZW = $clog2(sram_pkg::ZQ_PERIOD_CYC);
  localparam logic [KW-1:0] LOCK_LAST = KW'(sram_pkg::PLL_LOCK_CYC - 1);
  localparam logic [SW-1:0] STOP_MIN  = SW'(sram_pkg::PLL_RESET_CYC);
  localparam logic [ZW-1:0] ZQ_LAST   = ZW'(sram_pkg::ZQ_PERIOD_CYC - 1);
  localparam logic [PW-1:0] PIN_RST   =
    {2'b11, (AW + 2 * DW)'(0), {(2 * LN){1'b1}}, 1'b1, 3'b000};

  typedef struct packed {
    sram_pkg::start_kind_t last;      // start on the previous rise
    logic [1:0]            rpipe;     // read burst in cycle t+1 / t+2
    logic                  rleg;      // burst runs with one cycle latency
    logic                  rfwd;      // upper words still to forward
    logic [LW-1:0]         rline;     // read burst being sent
    logic [1:0]            wphase;    // write data in cycle t+1 / t+2
    logic [AW-1:0]         waddr;     // write burst address
    logic [LW-1:0]         wline;     // write words collected so far
    logic [MW-1:0]         wmask;     // lanes enabled so far
    logic [DW-1:0]         q_rise;    // read word, rising phase
    logic [DW-1:0]         q_fall;    // read word, falling phase
    logic                  oe_rise;   // drive rising-phase word
    logic                  oe_fall;   // drive falling-phase word
    logic                  echo;      // echo clock level
    logic [SW-1:0]         stop_cnt;  // cycles without input clock
    logic [KW-1:0]         lock_cnt;  // cycles of stable clock
    logic                  locked;    // pll counted as locked
    logic [ZW-1:0]         zq_cnt;    // impedance period counter
    logic                  zq_pulse;  // impedance update strobe
  } state_t;

  state_t                st_q;
  state_t                st_d;
  logic   [PW-1:0]       pins_s;      // synchronised pins
  logic                  rps_n_s;
  logic                  wps_n_s;
  logic   [AW-1:0]       addr_s;
  logic   [DW-1:0]       wd_rise_s;
  logic   [DW-1:0]       wd_fall_s;
  logic   [LN-1:0]       bws_rise_s;
  logic   [LN-1:0]       bws_fall_s;
  logic                  pll_en_s;
  logic                  single_s;
  logic                  present_s;
  logic                  outclk_s;
  logic   [LW-1:0]       mem [2**AW]; // storage array
  logic   [LW-1:0]       inc_line;    // write words arriving now
  logic   [MW-1:0]       inc_mask;
  logic   [LW-1:0]       wline_eff;   // write burst including this cycle
  logic   [MW-1:0]       wmask_eff;
  logic   [LW-1:0]       rline_eff;   // read burst with late forwarding
  logic   [LW-1:0]       fetch_line;  // newest data at the read address
  logic                  fetch_fwd;
  logic                  stall;       // array drain and reads held
  logic                  rd_ok;
  logic                  wr_ok;
  sram_pkg::port_req_t   req;
  logic                  start_rd;
  logic                  start_wr;
  logic                  fifo_push;
  logic                  fifo_in_ready;
  logic                  head_valid;
  logic   [FW-1:0]       head;
  logic   [QW-1:0]       fifo_level;

  // overlay enabled lanes of one line onto another
  function automatic logic [LW-1:0] merge_line(
    input logic [LW-1:0] old_l,
    input logic [LW-1:0] new_l,
    input logic [MW-1:0] en
  );
    logic [LW-1:0] r;
    r = old_l;
    for (int i = 0; i < MW; i++) begin
      if (en[i]) begin
        r[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
          new_l[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
      end
    end
    return r;
  endfunction : merge_line

  // every pin except mclk and rst_n passes two flops before use
  sram_pin_sync #(
    .W   (PW),
    .RST (PIN_RST)
  ) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({read_port_select_n, write_port_select_n, addr, wdata_rise,
             wdata_fall, byte_write_select_n_rise,
             byte_write_select_n_fall, pll_disable_n, single_clock_mode,
             in_clk_present, out_clk_level}),
    .q     (pins_s)
  );

  assign {rps_n_s, wps_n_s, addr_s, wd_rise_s, wd_fall_s, bws_rise_s,
          bws_fall_s, pll_en_s, single_s, present_s, outclk_s} = pins_s;

  // write words of this cycle; inputs ignored outside a burst
  always_comb begin
    inc_line = '0;
    inc_mask = '0;
    for (int p = 0; p < 2; p++) begin
      if (st_q.wphase[p]) begin
        inc_line[(2*p)*DW +: DW]   = wd_rise_s;
        inc_line[(2*p+1)*DW +: DW] = wd_fall_s;
        inc_mask[(2*p)*LN +: LN]   = ~bws_rise_s;
        inc_mask[(2*p+1)*LN +: LN] = ~bws_fall_s;
      end
    end
  end

  assign wline_eff = merge_line(st_q.wline, inc_line, inc_mask);
  assign wmask_eff = st_q.wmask | inc_mask;
  assign rline_eff = (st_q.rfwd && st_q.rpipe[0] && st_q.wphase[1]) ?
                     merge_line(st_q.rline, inc_line, inc_mask) :
                     st_q.rline;

  // newest data at the read address: array, queue head, open burst
  always_comb begin
    fetch_line = mem[addr_s];
    fetch_fwd  = 1'b0;
    if (head_valid && head[FW-1 -: AW] == addr_s) begin
      fetch_line = merge_line(fetch_line, head[MW +: LW], head[MW-1:0]);
    end
    if (st_q.wphase != 2'b00 && st_q.waddr == addr_s) begin
      fetch_line = merge_line(fetch_line, wline_eff, wmask_eff);
      fetch_fwd  = st_q.wphase[0];
    end
  end

  // start qualification and arbitration
  assign stall    = pll_en_s && !st_q.locked;
  assign rd_ok    = !stall && fifo_level <= QW'(1);
  assign wr_ok    = fifo_level < QW'(DEPTH - 1);
  assign req.rd   = !rps_n_s && st_q.last != sram_pkg::START_READ
                    && rd_ok;
  assign req.wr   = !wps_n_s && st_q.last != sram_pkg::START_WRITE
                    && wr_ok;
  assign start_rd = req.rd;
  assign start_wr = req.wr && !req.rd;
  assign fifo_push = st_q.wphase[1];

  // next state of the whole core
  always_comb begin
    st_d = st_q;
    // start history, set from the qualified starts only
    if (start_rd) begin
      st_d.last = sram_pkg::START_READ;
    end else if (start_wr) begin
      st_d.last = sram_pkg::START_WRITE;
    end else begin
      st_d.last = sram_pkg::START_NONE;
    end
    // read output words; floating unless a burst owns the phase
    st_d.oe_rise = 1'b0;
    st_d.oe_fall = 1'b0;
    if (st_q.rpipe[1] && !st_q.rleg) begin
      st_d.q_rise  = rline_eff[3*DW +: DW];
      st_d.oe_rise = 1'b1;
    end
    if (st_q.rpipe[0]) begin
      st_d.oe_rise = 1'b1;
      st_d.oe_fall = 1'b1;
      if (st_q.rleg) begin
        st_d.q_rise = rline_eff[2*DW +: DW];
        st_d.q_fall = rline_eff[3*DW +: DW];
      end else begin
        st_d.q_rise = rline_eff[DW +: DW];
        st_d.q_fall = rline_eff[2*DW +: DW];
      end
    end
    st_d.rline = rline_eff;
    st_d.rfwd  = 1'b0;
    if (start_rd) begin
      st_d.rline   = fetch_line;
      st_d.rfwd    = fetch_fwd;
      st_d.rleg    = !pll_en_s;
      st_d.q_fall  = pll_en_s ? fetch_line[0 +: DW] : fetch_line[DW +: DW];
      st_d.oe_fall = 1'b1;
      if (!pll_en_s) begin
        st_d.q_rise  = fetch_line[0 +: DW];
        st_d.oe_rise = 1'b1;
      end
    end
    st_d.rpipe = {st_q.rpipe[0], start_rd};
    // write burst collection
    st_d.wphase = {st_q.wphase[0], start_wr};
    st_d.wline  = wline_eff;
    st_d.wmask  = wmask_eff;
    if (start_wr) begin
      st_d.waddr = addr_s;
      st_d.wline = '0;
      st_d.wmask = '0;
    end
    // echo clocks from input or output clock
    st_d.echo = single_s ? !st_q.echo : outclk_s;
    // pll lock tracking
    if (!pll_en_s) begin
      st_d.lock_cnt = '0;
      st_d.locked   = 1'b0;
      st_d.stop_cnt = '0;
    end else if (!present_s) begin
      if (st_q.stop_cnt != STOP_MIN) begin
        st_d.stop_cnt = st_q.stop_cnt + 1'b1;
      end else begin
        st_d.lock_cnt = '0;
        st_d.locked   = 1'b0;
      end
    end else begin
      st_d.stop_cnt = '0;
      if (!st_q.locked) begin
        st_d.lock_cnt = st_q.lock_cnt + 1'b1;
        st_d.locked   = (st_q.lock_cnt == LOCK_LAST);
      end
    end
    // periodic impedance update
    st_d.zq_cnt   = st_q.zq_cnt + 1'b1;
    st_d.zq_pulse = (st_q.zq_cnt == ZQ_LAST);
  end

  // core state; comes up idle and floating, frozen if mclk stops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // completed bursts wait here until the array takes them
  sram_wr_fifo #(
    .W     (FW),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({st_q.waddr, wline_eff, wmask_eff}),
    .out_valid (head_valid),
    .out_ready (!stall),
    .out_data  (head),
    .level     (fifo_level)
  );

  // array commit, only enabled lanes change
  always_ff @(posedge mclk) begin
    if (head_valid && !stall) begin
      mem[head[FW-1 -: AW]] <= merge_line(mem[head[FW-1 -: AW]],
                                          head[MW +: LW], head[MW-1:0]);
    end
  end

  assign rdata_rise       = st_q.q_rise;
  assign rdata_fall       = st_q.q_fall;
  assign rdata_oe_rise    = st_q.oe_rise;
  assign rdata_oe_fall    = st_q.oe_fall;
  assign echo_clock       = st_q.echo;
  assign echo_clock_n     = !st_q.echo;
  assign pll_locked       = st_q.locked;
  assign impedance_update = st_q.zq_pulse;

  // checks on the core's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_pll_read;
    rdata_oe_fall ##1 (rdata_oe_rise && rdata_oe_fall) ##1 rdata_oe_rise;
  endsequence
  sequence s_both_from_idle;
    !rps_n_s && !wps_n_s && st_q.last == sram_pkg::START_NONE
    && rd_ok && wr_ok;
  endsequence

  property p_read_pll;
    start_rd && pll_en_s |=> s_pll_read
      and rdata_fall == $past(fetch_line[DW-1:0]);
  endproperty
  a_read_pll: assert property (p_read_pll)
    else $error("pll read burst timing wrong");

  property p_read_legacy;
    start_rd && !pll_en_s |=> (rdata_oe_rise && rdata_oe_fall)[*2];
  endproperty
  a_read_legacy: assert property (p_read_legacy)
    else $error("legacy read burst timing wrong");

  property p_no_back_read;
    start_rd |=> !start_rd;
  endproperty
  a_no_back_read: assert property (p_no_back_read)
    else $error("reads started on consecutive rises");

  property p_no_back_write;
    start_wr |=> !start_wr;
  endproperty
  a_no_back_write: assert property (p_no_back_write)
    else $error("writes started on consecutive rises");

  property p_read_priority;
    !rps_n_s && !wps_n_s && rd_ok && wr_ok
      && st_q.last != sram_pkg::START_READ |-> start_rd && !start_wr;
  endproperty
  a_read_priority: assert property (p_read_priority)
    else $error("arbitration ignored history");

  property p_alternate;
    s_both_from_idle ##1 (!wps_n_s && wr_ok) |-> start_wr;
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("no write after first read with both selected");

  property p_commit;
    start_wr |-> ##2 (fifo_push && fifo_in_ready);
  endproperty
  a_commit: assert property (p_commit)
    else $error("write burst not queued two cycles after start");

  property p_float_idle;
    st_q.rpipe == 2'b00 && !start_rd |=> !rdata_oe_rise && !rdata_oe_fall;
  endproperty
  a_float_idle: assert property (p_float_idle)
    else $error("read outputs driven with no burst");

  property p_unlocked_no_read;
    pll_en_s && !pll_locked |-> !start_rd;
  endproperty
  a_unlocked_no_read: assert property (p_unlocked_no_read)
    else $error("read started before pll lock");

  property p_zq_spacing;
    impedance_update |=> !impedance_update [*8];
  endproperty
  a_zq_spacing: assert property (p_zq_spacing)
    else $error("impedance updates too close together");

endmodule : ddr_burst_sram

/* File: src/sram_pin_sync.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes the pins are quasi-static relative to mclk
`timescale 1ns/100ps
module sram_pin_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // pin side and core side
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);

  typedef struct packed {
    logic [W-1:0] s1;   // first stage, read only by s2
    logic [W-1:0] s2;   // settled copy
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // shift the pins through two stages
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // register with synchronous reset to idle levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '{s1: RST, s2: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : sram_pin_sync

/* File: src/sram_pkg.sv */
// shared constants and types of the split-port burst-of-four memory
// assumes a single 50 MHz core clock standing in for the input clock
package sram_pkg;

  // organisation
  localparam int DATA_W     = 18;          // word width, 9, 18 or 36
  localparam int LANE_W     = 9;           // one byte lane with parity
  localparam int ADDR_W     = 8;           // burst locations, kept small
  localparam int BURST_LEN  = 4;           // words moved per access
  localparam int FIFO_DEPTH = 16;          // queued write bursts

  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int PLL_LOCK_US   = 20;       // stable clock before lock
  localparam int PLL_LOCK_CYC  =
    (PLL_LOCK_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int PLL_RESET_NS  = 30;       // least clock stop for relock
  localparam int PLL_RESET_CYC =
    (PLL_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ZQ_PERIOD_CYC = 1024;     // impedance update period

  // which port started an access on the previous rise
  typedef enum logic [1:0] {
    START_NONE,
    START_READ,
    START_WRITE
  } start_kind_t;

  // port requests after qualification
  typedef struct packed {
    logic rd;
    logic wr;
  } port_req_t;

endpackage : sram_pkg

/* File: src/sram_wr_fifo.sv */
// queue of completed write bursts waiting for the array
// assumes the producer honours in_ready and the consumer may stall
`timescale 1ns/100ps
module sram_wr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // filling side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // draining side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  // occupancy
  output logic      [LW-1:0] level
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;    // next slot to fill
    logic [PW-1:0] rp;    // oldest entry
    logic [LW-1:0] cnt;   // entries held
  } fifo_t;

  fifo_t        st_q;
  fifo_t        st_d;
  logic [W-1:0] mem [DEPTH];   // entry storage
  logic         push;
  logic         pop;

  assign in_ready  = (st_q.cnt != FULL);
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = mem[st_q.rp];
  assign level     = st_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wp = (st_q.wp == PW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == PW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + LW'(push) - LW'(pop);
  end

  // state register, empty after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // entry write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st_q.wp] <= in_data;
    end
  end

endmodule : sram_wr_fifo
